// ---- bench/mcsel_chk.sv ----
// Assertion checker for the clock select block
`timescale 1ns/1ns
module mcsel_chk
   import mcsel_pkg::*;
#(
   parameter int MCLK_RATIO_BASE = MCSEL_MCLK_RATIO_BASE,
   parameter int MCLK_RATIO_A = MCSEL_MCLK_RATIO_A,
   parameter int MCLK_RATIO_B = MCSEL_MCLK_RATIO_B
)
(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire mcsel_bus_req_type bus_req_i,
   input wire logic [MCSEL_DATA_W-1:0] bus_rdata_o,
   input wire logic master_clk_en_o,
   input wire logic [1:0] master_clk_sel_o,
   input wire logic cpu_clk_o,
   input wire logic cpu_clk_en_o,
   input wire logic [MCSEL_CODE_W-1:0] cpu_clock_divide_code_o
);
   logic [7:0] gap_q, gap_d, tk_q, tk_d, qt_q, qt_d, rat, half;
   logic cpu_p_q, cs_q, cs_d;
   logic [1:0] sel_p_q;
   logic [2:0] code_p_q;
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);
   // ***********************************************************
   // Helper counters
   // ***********************************************************
   always_comb
   begin
      rat = 8'(master_clk_sel_o == 2'h2 ? MCLK_RATIO_B :
         master_clk_sel_o == 2'h1 ? MCLK_RATIO_A : MCLK_RATIO_BASE);
      half = 8'(1 << (code_p_q == 3'h7 ? 7 : code_p_q + 1));
      gap_d = master_clk_en_o ? 8'h01 : gap_q + 8'h01;
      tk_d = (cpu_p_q != cpu_clk_o) ? 8'h00 : tk_q + {7'h00, master_clk_en_o};
      qt_d = (sys_rst_i || sel_p_q != master_clk_sel_o) ? 8'h00 : qt_q + {7'h00, qt_q != 8'hFF};
      cs_d = (sys_rst_i || code_p_q != cpu_clock_divide_code_o) ? 1'b0 :
         (cpu_p_q != cpu_clk_o) ? 1'b1 : cs_q;
   end
   always_ff @(posedge core_clk_i)
   begin
      gap_q <= gap_d;
      tk_q <= tk_d;
      qt_q <= qt_d;
      cs_q <= cs_d;
      cpu_p_q <= cpu_clk_o;
      sel_p_q <= master_clk_sel_o;
      code_p_q <= cpu_clock_divide_code_o;
   end
   // ***********************************************************
   // Checks
   // ***********************************************************
   sequence s_set_b;
      bus_req_i.wr && bus_req_i.addr == MCSEL_ADDR_MCLK && bus_req_i.wdata[MCSEL_RAISE_B_BIT];
   endsequence
   sequence s_zero_wr;
      bus_req_i.wr && bus_req_i.addr == MCSEL_ADDR_MCLK && bus_req_i.wdata == 8'h00;
   endsequence
   a_tick_gap: assert property (master_clk_en_o && qt_q > 8'(2 * MCLK_RATIO_BASE + 2)
      |-> gap_q == rat) else $error("master tick spacing wrong");
   a_sel_keep: assert property (master_clk_sel_o != 2'h0
      |=> master_clk_sel_o >= $past(master_clk_sel_o)) else $error("master setting fell");
   a_raise_b_sel: assert property (s_set_b |-> ##2 master_clk_sel_o == 2'h2)
      else $error("raise b not applied");
   a_zero_ignored: assert property (s_zero_wr |-> ##2 $stable(master_clk_sel_o))
      else $error("zero write changed setting");
   a_en_on_rise: assert property (cpu_clk_en_o == $rose(cpu_clk_o))
      else $error("cpu enable not on rise");
   a_cpu_on_tick: assert property ($changed(cpu_clk_o) |-> master_clk_en_o)
      else $error("cpu clock moved off tick");
   a_half_len: assert property ($changed(cpu_clk_o) && cs_q |-> tk_q + 8'h01 == half)
      else $error("cpu half period wrong");
   a_switch_low: assert property ($changed(cpu_clock_divide_code_o)
      |-> !cpu_clk_o && master_clk_en_o) else $error("code switched while high");
endmodule // mcsel_chk

bind mcsel_top mcsel_chk #(.MCLK_RATIO_BASE(MCLK_RATIO_BASE), .MCLK_RATIO_A(MCLK_RATIO_A),
   .MCLK_RATIO_B(MCLK_RATIO_B)) u_chk (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
   .bus_req_i(bus_req_i), .bus_rdata_o(bus_rdata_o), .master_clk_en_o(master_clk_en_o),
   .master_clk_sel_o(master_clk_sel_o), .cpu_clk_o(cpu_clk_o), .cpu_clk_en_o(cpu_clk_en_o),
   .cpu_clock_divide_code_o(cpu_clock_divide_code_o));

// ---- bench/tb.sv ----
// Self-checking testbench for the clock select block
`timescale 1ns/1ns
module tb;
   import mcsel_pkg::*;
   localparam int RAT_BASE = 4;
   localparam int RAT_A = 3;
   localparam int RAT_B = 2;
   logic core_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   mcsel_bus_req_type bus_req_i = '0;
   logic [7:0] bus_rdata_o;
   logic master_clk_en_o, cpu_clk_o, cpu_clk_en_o;
   logic [1:0] master_clk_sel_o;
   logic [2:0] cpu_clock_divide_code_o;
   int fails = 0;
   int cmp_count = 0;
   int n, k;
   mcsel_top #(.MCLK_RATIO_BASE(RAT_BASE), .MCLK_RATIO_A(RAT_A), .MCLK_RATIO_B(RAT_B)) u_dut (
      .core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .bus_req_i(bus_req_i),
      .bus_rdata_o(bus_rdata_o), .master_clk_en_o(master_clk_en_o),
      .master_clk_sel_o(master_clk_sel_o), .cpu_clk_o(cpu_clk_o), .cpu_clk_en_o(cpu_clk_en_o),
      .cpu_clock_divide_code_o(cpu_clock_divide_code_o));
   always #4 core_clk_i = ~core_clk_i;
   // ***********************************************************
   // Tasks
   // ***********************************************************
   task chk(input logic [15:0] s, input logic [15:0] e);
      cmp_count++;
      if (s !== e)
      begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task cyc;
      @(posedge core_clk_i);
      #1;
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk_i);
      bus_req_i.addr <= a;
      bus_req_i.wdata <= d;
      bus_req_i.wr <= 1'b1;
      @(posedge core_clk_i);
      bus_req_i.wr <= 1'b0;
   endtask
   task rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge core_clk_i);
      bus_req_i.addr <= a;
      bus_req_i.rd <= 1'b1;
      @(posedge core_clk_i);
      bus_req_i.rd <= 1'b0;
      #1;
      chk(16'(bus_rdata_o), 16'(e));
   endtask
   task tick_gap(output int g);
      for (g = 0; g < 200 && !master_clk_en_o; g++) cyc();
      g = 0;
      do
      begin
         cyc();
         g++;
      end
      while (!master_clk_en_o && g < 200);
   endtask
   task cpu_per(output int p);
      for (k = 0; k < 5000 && !cpu_clk_en_o; k++) cyc();
      p = 0;
      do
      begin
         cyc();
         p += int'(master_clk_en_o);
      end
      while (!cpu_clk_en_o && p < 1000);
   endtask
   task report_and_stop;
      $display("compares=%0d mismatches=%0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ***********************************************************
   // Stimulus
   // ***********************************************************
   initial
   begin
      #(40000 * 8);
      fails++;
      report_and_stop();
   end
   initial
   begin
      repeat (3) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      rd(MCSEL_ADDR_DIV, 8'h00);
      rd(MCSEL_ADDR_MCLK, 8'h00);
      rd(MCSEL_ADDR_STAT, 8'h00);
      tick_gap(n);
      chk(16'(n), 16'(RAT_BASE));
      $display("test reset values done");
      for (int c = 0; c < 8; c++)
      begin
         wr(MCSEL_ADDR_DIV, 8'(c));
         rd(MCSEL_ADDR_DIV, 8'(c));
         for (k = 0; k < 4000 && cpu_clock_divide_code_o !== 3'(c); k++) cyc();
         rd(MCSEL_ADDR_STAT, 8'(c));
         cpu_per(n);
         chk(16'(n), 16'(4 << (c == 7 ? 6 : c)));
      end
      $display("test divider codes done");
      wr(MCSEL_ADDR_MCLK, 8'h10);
      rd(MCSEL_ADDR_MCLK, 8'h10);
      wr(MCSEL_ADDR_MCLK, 8'h00);
      rd(MCSEL_ADDR_MCLK, 8'h10);
      chk(16'(master_clk_sel_o), 16'h0001);
      tick_gap(n);
      chk(16'(n), 16'(RAT_A));
      wr(MCSEL_ADDR_MCLK, 8'h01);
      wr(MCSEL_ADDR_MCLK, 8'h00);
      rd(MCSEL_ADDR_MCLK, 8'h11);
      chk(16'(master_clk_sel_o), 16'h0002);
      tick_gap(n);
      chk(16'(n), 16'(RAT_B));
      $display("test master setting done");
      @(posedge core_clk_i);
      sys_rst_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      rd(MCSEL_ADDR_MCLK, 8'h00);
      rd(MCSEL_ADDR_DIV, 8'h00);
      chk(16'(master_clk_sel_o), 16'h0000);
      $display("test second reset done");
      report_and_stop();
   end
endmodule // tb

// ---- design/mcsel_tick_div.sv ----
// Reloadable tick divider producing the master clock enable
`timescale 1ns/1ns
module mcsel_tick_div
   import mcsel_pkg::*;
#(
   parameter int WIDTH = MCSEL_MCLK_CNT_W
)
(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire logic [WIDTH-1:0] ratio_i,
   output logic tick_o
);

   // ***********************************************************************
   // Elaboration check
   // ***********************************************************************
   if (WIDTH < 1 || WIDTH > 16)
   begin : g_bad_width
      $error("mcsel_tick_div: WIDTH out of range");
   end

   logic [WIDTH-1:0] cnt_d;
   logic [WIDTH-1:0] cnt_q;
   logic tick_d;
   logic tick_q;

   // ***********************************************************************
   // Count down; new ratio loads only at the wrap
   // ***********************************************************************
   always_comb
   begin
      cnt_d = cnt_q - WIDTH'(1);
      tick_d = 1'b0;
      if (cnt_q == '0)
      begin
         cnt_d = (ratio_i == '0) ? '0 : ratio_i - WIDTH'(1);
         tick_d = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick_o = tick_q;

endmodule // mcsel_tick_div

// ---- design/mcsel_top.sv ----
// Master clock select and processor clock divider with register port
//
// Operation
// - Selection bits choose the master clock frequency
// - Selection bits set by software, cleared by reset
// - Writing zero to a selection bit is ignored
// - Codes 0 to 6 divide master by 4..256
// - Code 7 divides by 256 like code 6
// - Code may change while running from divided clock
//
// Local design decision: strobed register access.
`timescale 1ns/1ns
module mcsel_top
   import mcsel_pkg::*;
#(
   parameter int MCLK_RATIO_BASE = MCSEL_MCLK_RATIO_BASE,
   parameter int MCLK_RATIO_A = MCSEL_MCLK_RATIO_A,
   parameter int MCLK_RATIO_B = MCSEL_MCLK_RATIO_B
)
(
   input wire logic core_clk_i,
   input wire logic sys_rst_i,
   input wire mcsel_bus_req_type bus_req_i,
   output logic [MCSEL_DATA_W-1:0] bus_rdata_o,
   output logic master_clk_en_o,
   output logic [1:0] master_clk_sel_o,
   output logic cpu_clk_o,
   output logic cpu_clk_en_o,
   output logic [MCSEL_CODE_W-1:0] cpu_clock_divide_code_o
);

   // ***********************************************************************
   // Elaboration checks
   // ***********************************************************************
   if (MCLK_RATIO_BASE < 1 || MCLK_RATIO_BASE >= (1 << MCSEL_MCLK_CNT_W))
   begin : g_bad_base
      $error("mcsel_top: MCLK_RATIO_BASE out of range");
   end
   if (MCLK_RATIO_A < 1 || MCLK_RATIO_A >= (1 << MCSEL_MCLK_CNT_W))
   begin : g_bad_a
      $error("mcsel_top: MCLK_RATIO_A out of range");
   end
   if (MCLK_RATIO_B < 1 || MCLK_RATIO_B >= (1 << MCSEL_MCLK_CNT_W))
   begin : g_bad_b
      $error("mcsel_top: MCLK_RATIO_B out of range");
   end

   localparam logic [MCSEL_MCLK_CNT_W-1:0] RATIO_BASE_C =
      MCSEL_MCLK_CNT_W'(MCLK_RATIO_BASE);
   localparam logic [MCSEL_MCLK_CNT_W-1:0] RATIO_A_C = MCSEL_MCLK_CNT_W'(MCLK_RATIO_A);
   localparam logic [MCSEL_MCLK_CNT_W-1:0] RATIO_B_C = MCSEL_MCLK_CNT_W'(MCLK_RATIO_B);

   // ***********************************************************************
   // Declarations
   // ***********************************************************************
   logic wr_div;
   logic wr_mclk;
   logic raise_a_d;
   logic raise_a_q;
   logic raise_b_d;
   logic raise_b_q;
   logic [MCSEL_CODE_W-1:0] req_code_d;
   logic [MCSEL_CODE_W-1:0] req_code_q;
   logic [MCSEL_DATA_W-1:0] rdata_d;
   logic [MCSEL_DATA_W-1:0] rdata_q;

   mcsel_mclk_sel_type msel_d;
   mcsel_mclk_sel_type msel_q;
   logic [MCSEL_MCLK_CNT_W-1:0] mratio;
   logic mtick;
   logic mtick_q;

   logic [MCSEL_CPU_CNT_W-1:0] cnt_d;
   logic [MCSEL_CPU_CNT_W-1:0] cnt_q;
   logic [MCSEL_CODE_W-1:0] act_code_d;
   logic [MCSEL_CODE_W-1:0] act_code_q;
   logic cpu_clk_d;
   logic cpu_clk_q;
   logic cpu_en_d;
   logic cpu_en_q;
   logic pending;

   // Bit of the shared counter that carries the divided clock for a code
   function automatic logic [2:0] code_bit(input logic [MCSEL_CODE_W-1:0] code);
      logic [MCSEL_CODE_W-1:0] c;
      c = (code > MCSEL_CODE_TOP) ? MCSEL_CODE_TOP : code;
      code_bit = c + 3'h1;
   endfunction

   // ***********************************************************************
   // Register writes
   // ***********************************************************************
   assign wr_div = bus_req_i.wr && (bus_req_i.addr == MCSEL_ADDR_DIV);
   assign wr_mclk = bus_req_i.wr && (bus_req_i.addr == MCSEL_ADDR_MCLK);

   always_comb
   begin
      raise_a_d = raise_a_q;
      raise_b_d = raise_b_q;
      req_code_d = req_code_q;
      if (wr_mclk)
      begin
         // Ones set, zeros leave the bit alone
         raise_a_d = raise_a_q | bus_req_i.wdata[MCSEL_RAISE_A_BIT];
         raise_b_d = raise_b_q | bus_req_i.wdata[MCSEL_RAISE_B_BIT];
      end
      if (wr_div)
      begin
         req_code_d = bus_req_i.wdata[MCSEL_CODE_LSB +: MCSEL_CODE_W];
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         raise_a_q <= MCSEL_RAISE_RST;
         raise_b_q <= MCSEL_RAISE_RST;
         req_code_q <= MCSEL_CODE_RST;
      end
      else
      begin
         raise_a_q <= raise_a_d;
         raise_b_q <= raise_b_d;
         req_code_q <= req_code_d;
      end
   end

   // ***********************************************************************
   // Register reads
   // ***********************************************************************
   assign pending = (req_code_q != act_code_q);

   always_comb
   begin
      rdata_d = '0;
      if (bus_req_i.rd)
      begin
         unique case (bus_req_i.addr)
            MCSEL_ADDR_DIV:
            begin
               rdata_d[MCSEL_CODE_LSB +: MCSEL_CODE_W] = req_code_q;
            end
            MCSEL_ADDR_MCLK:
            begin
               rdata_d[MCSEL_RAISE_A_BIT] = raise_a_q;
               rdata_d[MCSEL_RAISE_B_BIT] = raise_b_q;
            end
            MCSEL_ADDR_STAT:
            begin
               rdata_d[MCSEL_CODE_LSB +: MCSEL_CODE_W] = act_code_q;
               rdata_d[MCSEL_STAT_PEND_BIT] = pending;
            end
            default:
            begin
               rdata_d = '0;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         rdata_q <= MCSEL_RDATA_RST;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   // ***********************************************************************
   // Master clock selection
   // ***********************************************************************
   always_comb
   begin
      msel_d = MCSEL_MCLK_BASE;
      if (raise_b_q)
      begin
         msel_d = MCSEL_MCLK_B;
      end
      else if (raise_a_q)
      begin
         msel_d = MCSEL_MCLK_A;
      end
   end

   always_comb
   begin
      unique case (msel_q)
         MCSEL_MCLK_BASE: mratio = RATIO_BASE_C;
         MCSEL_MCLK_A: mratio = RATIO_A_C;
         MCSEL_MCLK_B: mratio = RATIO_B_C;
         default: mratio = RATIO_BASE_C;
      endcase
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         msel_q <= MCSEL_MCLK_BASE;
      end
      else
      begin
         msel_q <= msel_d;
      end
   end

   mcsel_tick_div #(
      .WIDTH(MCSEL_MCLK_CNT_W)
   ) u_mclk_div (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .ratio_i(mratio),
      .tick_o(mtick)
   );

   // ***********************************************************************
   // Processor clock divider
   // ***********************************************************************
   always_comb
   begin
      cnt_d = cnt_q;
      act_code_d = act_code_q;
      cpu_clk_d = cpu_clk_q;
      cpu_en_d = 1'b0;
      if (mtick)
      begin
         cnt_d = cnt_q + MCSEL_CPU_CNT_W'(1);
         // Change ratio only where old and new divided clocks are both low
         if (pending && !cnt_d[code_bit(act_code_q)] && !cnt_d[code_bit(req_code_q)])
         begin
            act_code_d = req_code_q;
         end
         cpu_clk_d = cnt_d[code_bit(act_code_d)];
         cpu_en_d = cpu_clk_d && !cpu_clk_q;
      end
   end

   always_ff @(posedge core_clk_i)
   begin
      if (sys_rst_i)
      begin
         cnt_q <= '0;
         act_code_q <= MCSEL_CODE_RST;
         cpu_clk_q <= 1'b0;
         cpu_en_q <= 1'b0;
         mtick_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         act_code_q <= act_code_d;
         cpu_clk_q <= cpu_clk_d;
         cpu_en_q <= cpu_en_d;
         mtick_q <= mtick;
      end
   end

   // ***********************************************************************
   // Outputs
   // ***********************************************************************
   assign bus_rdata_o = rdata_q;
   assign master_clk_en_o = mtick_q;
   assign master_clk_sel_o = msel_q;
   assign cpu_clk_o = cpu_clk_q;
   assign cpu_clk_en_o = cpu_en_q;
   assign cpu_clock_divide_code_o = act_code_q;

endmodule // mcsel_top

// ---- include/mcsel_pkg.sv ----
// Package of constants and types for the master and processor clock select block
package mcsel_pkg;

   // ***********************************************************************
   // Register bus layout
   // ***********************************************************************
   localparam int MCSEL_ADDR_W = 16;
   localparam int MCSEL_DATA_W = 8;

   // Register offsets; the bus is byte addressed, one register per byte
   localparam logic [15:0] MCSEL_IDX_DIV = 16'h2004;
   localparam logic [15:0] MCSEL_IDX_MCLK = 16'h2005;
   localparam logic [15:0] MCSEL_IDX_STAT = 16'h2006;
   localparam logic [15:0] MCSEL_ADDR_DIV = MCSEL_IDX_DIV;
   localparam logic [15:0] MCSEL_ADDR_MCLK = MCSEL_IDX_MCLK;
   localparam logic [15:0] MCSEL_ADDR_STAT = MCSEL_IDX_STAT;

   // ***********************************************************************
   // Field positions and reset values
   // ***********************************************************************
   localparam int MCSEL_CODE_W = 3;
   localparam int MCSEL_CODE_LSB = 0;
   localparam int MCSEL_RAISE_A_BIT = 4;
   localparam int MCSEL_RAISE_B_BIT = 0;
   localparam int MCSEL_STAT_PEND_BIT = 3;
   localparam logic [2:0] MCSEL_CODE_RST = 3'h0;
   localparam logic MCSEL_RAISE_RST = 1'h0;
   localparam logic [7:0] MCSEL_RDATA_RST = 8'h00;

   // ***********************************************************************
   // Divider figures
   // ***********************************************************************
   localparam int MCSEL_CPU_CNT_W = 8;
   localparam logic [2:0] MCSEL_CODE_TOP = 3'h6;
   localparam int MCSEL_MCLK_CNT_W = 8;
   // Core cycles per master clock tick in each master clock setting
   localparam int MCSEL_MCLK_RATIO_BASE = 16;
   localparam int MCSEL_MCLK_RATIO_A = 8;
   localparam int MCSEL_MCLK_RATIO_B = 4;

   // ***********************************************************************
   // Types
   // ***********************************************************************
   typedef struct packed {
      logic [MCSEL_ADDR_W-1:0] addr;
      logic [MCSEL_DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } mcsel_bus_req_type;

   typedef enum logic [1:0] {
      MCSEL_MCLK_BASE = 2'b00,
      MCSEL_MCLK_A = 2'b01,
      MCSEL_MCLK_B = 2'b10
   } mcsel_mclk_sel_type;

endpackage
